// file: sces_pkg.sv
// Package: register map, field layout, reset values and modes
`default_nettype none
package sces_pkg;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int DIV_W = 16;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ENCNT_OFF = 8'h04;
  localparam logic [7:0] SWCNT_OFF = 8'h08;
  localparam logic [7:0] DIV_OFF = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;
  // Control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_RSTEN_BIT = 2;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_MT_BIT = 6;
  localparam int CTRL_TOPS_BIT = 7;
  localparam int CTRL_BOTS_BIT = 8;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0004;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0027;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TRIG_RISE,
    TRIG_FALL,
    TRIG_EITHER,
    TRIG_NONZERO
  } sces_trig_e;
endpackage
`default_nettype wire

// file: sces_restart_det.sv
// Restart event detector on a signed restart sample stream
`default_nettype none
module sces_restart_det #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Sample enable and mode
  input wire logic smp_en_in,
  input wire logic [1:0] trig_in,
  // Restart sample
  input wire logic signed [W-1:0] val_in,
  // Event, one sample enable wide
  output logic event_out
);
  logic signed [W-1:0] prev_ff, nxt_prev;
  logic rise_z_ff, nxt_rise_z;
  logic fall_z_ff, nxt_fall_z;
  logic hit;
  logic rise, fall, pn, pz, pp, cn, cz, cp;

  always_comb begin
    pn = prev_ff < 0;
    pz = prev_ff == 0;
    pp = prev_ff > 0;
    cn = val_in < 0;
    cz = val_in == 0;
    cp = val_in > 0;
    rise = (pn && !cn) || (pz && cp && !rise_z_ff);
    fall = (pp && !cp) || (pz && cn && !fall_z_ff);
    nxt_prev = prev_ff;
    nxt_rise_z = rise_z_ff;
    nxt_fall_z = fall_z_ff;
    hit = 1'b0;
    if (smp_en_in) begin
      nxt_prev = val_in;
      nxt_rise_z = pn && cz;
      nxt_fall_z = pp && cz;
      unique case (sces_pkg::sces_trig_e'(trig_in))
        sces_pkg::TRIG_RISE: hit = rise;
        sces_pkg::TRIG_FALL: hit = fall;
        sces_pkg::TRIG_EITHER: hit = rise || fall;
        sces_pkg::TRIG_NONZERO: hit = !cz;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prev_ff <= '0;
      rise_z_ff <= 1'b0;
      fall_z_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      rise_z_ff <= nxt_rise_z;
      fall_z_ff <= nxt_fall_z;
    end
  end
  // Event shows in the tick cycle, so outside multitask mode a restart lands on that same sample
  assign event_out = hit;
endmodule
`default_nettype wire

// file: sces_sample_div.sv
// Sample period divider making a one-cycle sample enable
`default_nettype none
module sces_sample_div #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic [W-1:0] div_in,
  // Enable pulse
  output logic tick_out
);
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run_in) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= div_in) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
  assign tick_out = tick_ff;
endmodule
`default_nettype wire

// file: sces_top.sv
// Sample count enable and switch with AXI4-Lite registers
// What this block does
// - Enable output is inactive level for first N samples after start/restart
// - From sample N+1 the enable output holds the active level
// - Enable output is one value per sample period
// - Restart event returns the enable counter to its initial state
// - Rising mode: negative to zero or positive is an event
// - Rising mode: zero to positive counts unless continuing a rise
// - Falling mode: positive to zero or negative is an event
// - Falling mode: zero to negative counts unless continuing a fall
// - Either mode: rising or falling condition is an event
// - Non-zero mode: each nonzero restart sample is an event
// - Multitask mode delays applying a restart by one sample
// - Switch passes top input for N samples, then bottom input
// - Switch output rate comes from the one sample divider shared with the enable output
// - Each data input is held between its own sample instants
// - A scalar data input is replicated across all lanes
// - Restart event clears the switch counter to zero
// - Switch changes to bottom input at time Ts times N+1
//
// Our own choices: the address map and the AXI4-Lite slave port.
`default_nettype none
module sces_top #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Data inputs with their own sample strobes
  input wire logic [LANES*sces_pkg::DATA_W-1:0] top_data_in,
  input wire logic top_valid_in,
  input wire logic [LANES*sces_pkg::DATA_W-1:0] bot_data_in,
  input wire logic bot_valid_in,
  // Restart sample stream
  input wire logic signed [sces_pkg::DATA_W-1:0] restart_in,
  // Outputs
  output logic enable_out,
  output logic [LANES*sces_pkg::DATA_W-1:0] switch_out,
  output logic sample_out
);
  localparam int DW = sces_pkg::DATA_W;
  localparam int CW = sces_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus slave
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [CW-1:0] en_n_ff, nxt_en_n;
  logic [CW-1:0] sw_n_ff, nxt_sw_n;
  logic [sces_pkg::DIV_W-1:0] div_ff, nxt_div;
  logic aw_ok_ff, nxt_aw_ok;
  logic w_ok_ff, nxt_w_ok;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic wr_go;
  logic [31:0] stat;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_aw_ok = aw_ok_ff;
    nxt_w_ok = w_ok_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_ctrl = ctrl_ff;
    nxt_en_n = en_n_ff;
    nxt_sw_n = sw_n_ff;
    nxt_div = div_ff;
    if (s_axi_awvalid && !aw_ok_ff && !bvalid_ff) begin
      nxt_aw_ok = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ok_ff && !bvalid_ff) begin
      nxt_w_ok = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;
    if (wr_go) begin
      nxt_aw_ok = 1'b0;
      nxt_w_ok = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = sces_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        sces_pkg::CTRL_OFF: nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
        sces_pkg::ENCNT_OFF:
          nxt_en_n = CW'(merge(32'(en_n_ff), wdata_ff, wstrb_ff));
        sces_pkg::SWCNT_OFF:
          nxt_sw_n = CW'(merge(32'(sw_n_ff), wdata_ff, wstrb_ff));
        sces_pkg::DIV_OFF: nxt_div =
          sces_pkg::DIV_W'(merge(32'(div_ff), wdata_ff, wstrb_ff));
        sces_pkg::STAT_OFF: nxt_bresp = sces_pkg::RESP_OKAY;
        default: nxt_bresp = sces_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = sces_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sces_pkg::CTRL_OFF: nxt_rdata = ctrl_ff;
        sces_pkg::ENCNT_OFF: nxt_rdata = 32'(en_n_ff);
        sces_pkg::SWCNT_OFF: nxt_rdata = 32'(sw_n_ff);
        sces_pkg::DIV_OFF: nxt_rdata = 32'(div_ff);
        sces_pkg::STAT_OFF: nxt_rdata = stat;
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = sces_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= sces_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= sces_pkg::RESP_OKAY;
      ctrl_ff <= sces_pkg::CTRL_RST;
      en_n_ff <= sces_pkg::CNT_RST;
      sw_n_ff <= sces_pkg::CNT_RST;
      div_ff <= sces_pkg::DIV_RST;
    end else begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctrl_ff <= nxt_ctrl;
      en_n_ff <= nxt_en_n;
      sw_n_ff <= nxt_sw_n;
      div_ff <= nxt_div;
    end
  end

  // Ready only while the slot is empty, so payload is never overwritten
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready = !w_ok_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sample enable and restart detection
  logic run, pol, rst_en, mt, top_scalar, bot_scalar;
  logic tick, det_event;
  assign run = ctrl_ff[sces_pkg::CTRL_RUN_BIT];
  assign pol = ctrl_ff[sces_pkg::CTRL_POL_BIT];
  assign rst_en = ctrl_ff[sces_pkg::CTRL_RSTEN_BIT];
  assign mt = ctrl_ff[sces_pkg::CTRL_MT_BIT];
  assign top_scalar = ctrl_ff[sces_pkg::CTRL_TOPS_BIT];
  assign bot_scalar = ctrl_ff[sces_pkg::CTRL_BOTS_BIT];

  sces_sample_div #(.W(sces_pkg::DIV_W)) u_div (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(run),
    .div_in(div_ff),
    .tick_out(tick)
  );

  // Restart stream is sampled once per tick; source rate
  sces_restart_det #(.W(DW)) u_det (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .smp_en_in(tick),
    .trig_in(ctrl_ff[sces_pkg::CTRL_TYPE_LSB +: 2]),
    .val_in(restart_in),
    .event_out(det_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counters, hold registers and outputs
  logic [CW-1:0] en_cnt_ff, nxt_en_cnt;
  logic [CW-1:0] sw_cnt_ff, nxt_sw_cnt;
  logic pend_ff, nxt_pend;
  logic [LANES*DW-1:0] top_hold_ff, nxt_top_hold;
  logic [LANES*DW-1:0] bot_hold_ff, nxt_bot_hold;
  logic enable_ff, nxt_enable;
  logic [LANES*DW-1:0] sw_out_ff, nxt_sw_out;
  logic smp_ff, nxt_smp;
  logic restart, en_done, sw_done;
  logic [CW-1:0] en_base, sw_base;

  always_comb begin
    // Restart applied on the next tick in multitask mode
    restart = rst_en && (mt ? (pend_ff && tick) : det_event);
    nxt_pend = pend_ff;
    if (tick) begin
      nxt_pend = 1'b0;
    end
    if (det_event && rst_en && mt) begin
      nxt_pend = 1'b1;
    end
    nxt_top_hold = top_hold_ff;
    nxt_bot_hold = bot_hold_ff;
    if (top_valid_in) begin
      nxt_top_hold = top_data_in;
      if (top_scalar) begin
        nxt_top_hold = {LANES{top_data_in[DW-1:0]}};
      end
    end
    if (bot_valid_in) begin
      nxt_bot_hold = bot_data_in;
      if (bot_scalar) begin
        nxt_bot_hold = {LANES{bot_data_in[DW-1:0]}};
      end
    end
    // A restart sample is sample 1 of the new count
    en_base = restart ? '0 : en_cnt_ff;
    sw_base = restart ? '0 : sw_cnt_ff;
    en_done = en_base >= en_n_ff;
    sw_done = sw_base >= sw_n_ff;
    nxt_en_cnt = en_cnt_ff;
    nxt_sw_cnt = sw_cnt_ff;
    nxt_enable = enable_ff;
    nxt_sw_out = sw_out_ff;
    nxt_smp = 1'b0;
    if (!run) begin
      nxt_en_cnt = '0;
      nxt_sw_cnt = '0;
      nxt_enable = !pol;
    end else if (tick) begin
      // Restart only comes with a tick: never a second sample per period
      // Saturate so the count never wraps back to inactive
      nxt_en_cnt = en_done ? en_base : en_base + CW'(1);
      nxt_sw_cnt = sw_done ? sw_base : sw_base + CW'(1);
      nxt_enable = en_done ? pol : !pol;
      nxt_sw_out = sw_done ? bot_hold_ff : top_hold_ff;
      nxt_smp = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      en_cnt_ff <= '0;
      sw_cnt_ff <= '0;
      pend_ff <= 1'b0;
      top_hold_ff <= '0;
      bot_hold_ff <= '0;
      enable_ff <= 1'b0;
      sw_out_ff <= '0;
      smp_ff <= 1'b0;
    end else begin
      en_cnt_ff <= nxt_en_cnt;
      sw_cnt_ff <= nxt_sw_cnt;
      pend_ff <= nxt_pend;
      top_hold_ff <= nxt_top_hold;
      bot_hold_ff <= nxt_bot_hold;
      enable_ff <= nxt_enable;
      sw_out_ff <= nxt_sw_out;
      smp_ff <= nxt_smp;
    end
  end

  assign stat = {sw_cnt_ff, en_cnt_ff[CW-3:0], pend_ff, enable_ff};
  assign enable_out = enable_ff;
  assign switch_out = sw_out_ff;
  assign sample_out = smp_ff;
endmodule
`default_nettype wire

// file: sces_top_assertions.sv
// Checker of bus handshakes and output timing of the block
`default_nettype none
module sces_top_chk #(
  parameter int LANES = 4
) (
  // Watched ports
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic enable_out,
  input wire logic [LANES*sces_pkg::DATA_W-1:0] switch_out,
  input wire logic sample_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) rst_in |=> !enable_out && !sample_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle");
  // Switch output moves only with a new sample
  property p_hold;
    $changed(switch_out) |-> sample_out;
  endproperty
  a_hold: assert property (p_hold) else $error("switch moved");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_bblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bblk: assert property (p_bblk) else $error("write taken too early");
  property p_rblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblk: assert property (p_rblk) else $error("read taken too early");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |=> s_axi_rresp == sces_pkg::RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_active: cover property (sample_out && enable_out);
endmodule
bind sces_top sces_top_chk #(.LANES(LANES)) u_sces_top_chk (
  .mclk_in, .rst_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .enable_out, .switch_out,
  .sample_out);
`default_nettype wire

// file: sces_src_model.sv
// Upstream model feeding the two data inputs
`default_nettype none
module sces_src_model #(
  parameter int W = 64
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // New value requests
  input wire logic [1:0] go_in,
  // Data streams
  output logic [W-1:0] top_out,
  output logic top_vld_out,
  output logic [W-1:0] bot_out,
  output logic bot_vld_out
);
  int seed = 40;
  // Both streams sample based, one strobe per value
  always @(posedge mclk_in) begin
    top_vld_out <= go_in[0] && !rst_in;
    bot_vld_out <= go_in[1] && !rst_in;
    if (rst_in) begin
      top_out <= '0;
      bot_out <= '0;
    end else begin
      // Lines toggle between strobes so stale data is never reused
      top_out <= go_in[0] ? W'({$random(seed), $random(seed)}) : ~top_out;
      bot_out <= go_in[1] ? W'({$random(seed), $random(seed)}) : ~bot_out;
    end
  end
endmodule
`default_nettype wire

// file: test_sample_count_enable_switch.sv
// Testbench of the sample count enable and switch block
`default_nettype none
module test_sample_count_enable_switch;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 64;
  logic mclk_in = 0;
  logic rst_in = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, top_valid_in, bot_valid_in;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, ctrl;
  logic [31:0] ctrl_hw = sces_pkg::CTRL_RST;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, go = 0;
  logic [W-1:0] top_data_in, bot_data_in, switch_out;
  logic [W-1:0] hold_top = 0, hold_bot = 0;
  logic enable_out, sample_out, pol, inact;
  logic signed [15:0] restart_in = 0;
  int fails = 0, compares = 0, seed = 40, cycles = 0, ne, ns, n;
  int cm[9] = '{0, 0, 1, 1, 2, 2, 3, 0, 3};
  int cb[9] = '{-2, 0, 2, 0, -1, 1, 0, 3, 0};
  int c1[9] = '{0, 5, 0, -4, 1, -1, 7, -1, 9};
  int c2[9] = '{3, 5, -3, -4, 1, -1, 0, -1, 9};
  int cr[9] = '{1, 1, 1, 1, 1, 1, 1, 0, 0};
  sces_top #(.LANES(4)) u_sces_top (.mclk_in, .rst_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .top_data_in, .top_valid_in,
    .bot_data_in, .bot_valid_in, .restart_in, .enable_out, .switch_out,
    .sample_out);
  sces_src_model #(.W(W)) u_sces_src_model (.mclk_in, .rst_in,
    .go_in(go), .top_out(top_data_in), .top_vld_out(top_valid_in),
    .bot_out(bot_data_in), .bot_vld_out(bot_valid_in));
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Bench copy of the last value strobed on each input
  always @(posedge mclk_in) begin
    cycles++;
    // Scalar lanes are spread with the control word in force at capture
    if (top_valid_in)
      hold_top <= rep(top_data_in, ctrl_hw[sces_pkg::CTRL_TOPS_BIT]);
    if (bot_valid_in)
      hold_bot <= rep(bot_data_in, ctrl_hw[sces_pkg::CTRL_BOTS_BIT]);
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] ex);
    compares++;
    if (seen !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, ex, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [W-1:0] rep(logic [W-1:0] v, logic s);
    return s ? {4{v[15:0]}} : v;
  endfunction
  function automatic logic [W-1:0] exp_sw(logic top);
    return top ? hold_top : hold_bot;
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    if (a == sces_pkg::CTRL_OFF) ctrl_hw = d;
    check("bresp", s_axi_bresp, sces_pkg::RESP_OKAY);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] ex, logic [1:0] er);
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge mclk_in);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    check("rdata", s_axi_rdata, ex);
    check("rresp", s_axi_rresp, er);
  endtask
  // Counters stopped while counts change, then both inputs loaded
  task automatic cfg(int a, int b);
    wr(sces_pkg::CTRL_OFF, '0);
    wr(sces_pkg::ENCNT_OFF, 32'(a));
    wr(sces_pkg::SWCNT_OFF, 32'(b));
    wr(sces_pkg::DIV_OFF, 32'h0000_0007);
    go <= 2'b11;
    @(posedge mclk_in);
    go <= 2'b00;
    ne = a;
    ns = b;
  endtask
  // New data only right after a sample, far from the next tick
  task automatic smp(int k);
    do @(posedge mclk_in); while (sample_out !== 1'b1);
    inact = enable_out === ~pol;
    if (k > 0) check("enable", enable_out, k <= ne ? !pol : pol);
    check("switch", switch_out, exp_sw(k > 0 ? k <= ns : inact));
    go <= 2'($random(seed));
    @(posedge mclk_in);
    go <= 2'b00;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 0;
    rd(sces_pkg::CTRL_OFF, sces_pkg::CTRL_RST, sces_pkg::RESP_OKAY);
    rd(sces_pkg::ENCNT_OFF, 32'(sces_pkg::CNT_RST), sces_pkg::RESP_OKAY);
    rd(sces_pkg::SWCNT_OFF, 32'(sces_pkg::CNT_RST), sces_pkg::RESP_OKAY);
    rd(sces_pkg::DIV_OFF, 32'(sces_pkg::DIV_RST), sces_pkg::RESP_OKAY);
    rd(8'h14, '0, sces_pkg::RESP_SLVERR);
    // First pass is the shortest enable count against a long switch
    for (int p = 0; p < 2; p++) begin
      pol = 1'($random(seed));
      cfg(p ? 2 + ($unsigned($random(seed)) % 4) : 1, p ? 1 : 5);
      ctrl = {23'h0, 2'($random(seed)), 5'h0, pol, 1'b1};
      wr(sces_pkg::CTRL_OFF, ctrl);
      for (int k = 1; k <= 8; k++) smp(k);
    end
    cfg(2 + ($unsigned($random(seed)) % 4), 0);
    cfg(ne, ne);
    for (int i = 0; i < 9; i++) begin
      ctrl = {23'h0, 2'($random(seed)), 1'($random(seed)), 2'(cm[i]),
        1'b0, 1'(i < 8), pol, 1'b1};
      wr(sces_pkg::CTRL_OFF, ctrl);
      restart_in <= 16'(cb[i]);
      repeat (2 * ne + 6) smp(0);
      check("settled", enable_out, pol);
      restart_in <= 16'(c1[i]);
      smp(0);
      n = int'(inact);
      restart_in <= 16'(c2[i]);
      repeat (2 * ne + 8) begin
        smp(0);
        n += int'(inact);
      end
      check("inactive run", W'(n), W'(cr[i] * ne));
    end
    finish_test();
  end
endmodule
`default_nettype wire
